// file: rtl/adc_ctrl_pkg.sv
// Package: register map, field positions, reset values and types for ADC conversion control
package adc_ctrl_pkg;

    // Register offsets (byte addresses on the plain register port)
    localparam logic [7:0] mode_chan_off = 8'h00;
    localparam logic [7:0] busy_off = 8'h04;
    localparam logic [7:0] irq_status_off = 8'h08;
    localparam logic [7:0] irq_mask_off = 8'h0c;

    // Control register field positions
    localparam int done_bit = 7;
    localparam int capture_bit = 6;
    localparam int cont_bit = 5;
    localparam int single_bit = 4;
    localparam int chan_lsb = 0;
    localparam int chan_w = 4;

    // Reset values
    localparam logic [7:0] mode_chan_rst = 8'h00;
    localparam logic [1:0] irq_mask_rst = 2'h0;

    // Channel code that ends a block capture
    localparam logic [3:0] chan_stop = 4'hf;

    // Interrupt status bits
    localparam int ev_done = 0;
    localparam int ev_capture_end = 1;

    // Conversion control states
    typedef enum logic [2:0] {
        st_idle,
        st_convert,
        st_fetch,
        st_wait_id,
        st_store
    } conv_state_t;

    // Request to the analog converter
    typedef struct packed {
        logic start;
        logic [3:0] channel;
    } conv_req_t;

    // Request to the capture memory side
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] data;
    } mem_req_t;

endpackage

// file: rtl/adc_conversion_control.sv
// ADC conversion control: mode/channel register, conversion sequencing and block capture
//
// Chosen here: the address-and-strobe port and the placing of the registers.
module adc_conversion_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Core interrupt vectoring
    input wire logic vector_ack,
    output logic irq,
    // Analog converter
    output adc_ctrl_pkg::conv_req_t conv_req,
    input wire logic conv_done,
    input wire logic [11:0] conv_result,
    // Capture memory port
    output adc_ctrl_pkg::mem_req_t mem_req,
    input wire logic mem_ack,
    input wire logic [3:0] mem_chan_id,
    // External bus strobe
    input wire logic ale_core,
    output logic ale_out
);

    adc_ctrl_pkg::conv_state_t state_reg, state_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [1:0] status_reg, status_next;
    logic [1:0] mask_reg;
    logic busy_reg;
    logic capture_run_reg;
    logic single_run_reg;
    logic [3:0] cap_chan_reg;
    logic [11:0] result_reg;
    logic [7:0] rdata_next;
    adc_ctrl_pkg::conv_req_t conv_req_next;
    adc_ctrl_pkg::mem_req_t mem_req_next;
    logic ale_next;

    // Register port decode
    wire wr_ctrl = wr && (addr == adc_ctrl_pkg::mode_chan_off);
    wire wr_status = wr && (addr == adc_ctrl_pkg::irq_status_off);
    wire wr_mask = wr && (addr == adc_ctrl_pkg::irq_mask_off);
    wire [3:0] sw_chan = ctrl_reg[adc_ctrl_pkg::chan_lsb +: adc_ctrl_pkg::chan_w];
    wire cap_en = ctrl_reg[adc_ctrl_pkg::capture_bit];
    wire cont_en = ctrl_reg[adc_ctrl_pkg::cont_bit];
    wire single_set = wr_ctrl && wdata[adc_ctrl_pkg::single_bit];
    wire cap_set = wr_ctrl && wdata[adc_ctrl_pkg::capture_bit] && !cap_en;
    wire idle = (state_reg == adc_ctrl_pkg::st_idle);
    wire conv_end = (state_reg == adc_ctrl_pkg::st_convert) && conv_done;
    wire stop_seen = (state_reg == adc_ctrl_pkg::st_wait_id) && mem_ack
        && (mem_chan_id == adc_ctrl_pkg::chan_stop);
    wire single_end = conv_end && single_run_reg && !capture_run_reg;
    wire done_evt = single_end || stop_seen;
    // Continuous mode re-arms from the live channel field each time
    wire sw_start = idle && !cap_en && (single_set || cont_en);

    // Read data mux; flag reads show hardware state
    always_comb begin
        rdata_next = 8'h00;
        case (addr)
            adc_ctrl_pkg::mode_chan_off: rdata_next = ctrl_reg;
            adc_ctrl_pkg::busy_off: rdata_next = {busy_reg, 7'h00};
            adc_ctrl_pkg::irq_status_off: rdata_next = {6'h00, status_reg};
            adc_ctrl_pkg::irq_mask_off: rdata_next = {6'h00, mask_reg};
            default: rdata_next = 8'h00;
        endcase
    end

    // Control register: hardware sets win over software clears
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = wdata;
        end
        if (vector_ack) begin
            ctrl_next[adc_ctrl_pkg::done_bit] = 1'b0;
        end
        if (single_end) begin
            ctrl_next[adc_ctrl_pkg::single_bit] = 1'b0;
        end
        if (stop_seen) begin
            ctrl_next[adc_ctrl_pkg::capture_bit] = 1'b0;
        end
        if (done_evt) begin
            ctrl_next[adc_ctrl_pkg::done_bit] = 1'b1;
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always_comb begin
        status_next = status_reg;
        if (wr_status) begin
            status_next = status_reg & ~wdata[1:0];
        end
        if (done_evt) begin
            status_next[adc_ctrl_pkg::ev_done] = 1'b1;
        end
        if (stop_seen) begin
            status_next[adc_ctrl_pkg::ev_capture_end] = 1'b1;
        end
    end

    // Sequencer: single, continuous and block capture
    always_comb begin
        state_next = state_reg;
        conv_req_next = '0;
        mem_req_next = '0;
        case (state_reg)
            adc_ctrl_pkg::st_idle: begin
                if (cap_set) begin
                    state_next = adc_ctrl_pkg::st_fetch;
                end else if (sw_start) begin
                    conv_req_next.start = 1'b1;
                    conv_req_next.channel = single_set
                        ? wdata[adc_ctrl_pkg::chan_lsb +: adc_ctrl_pkg::chan_w]
                        : sw_chan;
                    state_next = adc_ctrl_pkg::st_convert;
                end
            end
            adc_ctrl_pkg::st_convert: begin
                if (conv_done) begin
                    state_next = capture_run_reg ? adc_ctrl_pkg::st_store
                        : adc_ctrl_pkg::st_idle;
                end
            end
            adc_ctrl_pkg::st_fetch: begin
                mem_req_next.rd = 1'b1;
                state_next = adc_ctrl_pkg::st_wait_id;
            end
            adc_ctrl_pkg::st_wait_id: begin
                if (mem_ack) begin
                    if (mem_chan_id == adc_ctrl_pkg::chan_stop) begin
                        state_next = adc_ctrl_pkg::st_idle;
                    end else begin
                        conv_req_next.start = 1'b1;
                        conv_req_next.channel = mem_chan_id;
                        state_next = adc_ctrl_pkg::st_convert;
                    end
                end
            end
            adc_ctrl_pkg::st_store: begin
                mem_req_next.wr = 1'b1;
                mem_req_next.data = result_reg;
                state_next = adc_ctrl_pkg::st_fetch;
            end
            default: state_next = adc_ctrl_pkg::st_idle;
        endcase
    end

    // Strobe held off from enable until capture actually starts
    assign ale_next = (cap_en && !capture_run_reg && !cap_set) ? 1'b0
        : (cap_set ? 1'b0 : ale_core);

    // State and register flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= adc_ctrl_pkg::st_idle;
            ctrl_reg <= adc_ctrl_pkg::mode_chan_rst;
            status_reg <= 2'h0;
            mask_reg <= adc_ctrl_pkg::irq_mask_rst;
            rdata <= 8'h00;
            conv_req <= '0;
            mem_req <= '0;
            ale_out <= 1'b0;
            irq <= 1'b0;
        end else begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            status_reg <= status_next;
            if (wr_mask) begin
                mask_reg <= wdata[1:0];
            end
            rdata <= rd ? rdata_next : 8'h00;
            conv_req <= conv_req_next;
            mem_req <= mem_req_next;
            ale_out <= ale_next;
            irq <= |(status_next & mask_reg);
        end
    end

    // Busy and mode tracking; busy spans start pulse to converter done
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
            capture_run_reg <= 1'b0;
            single_run_reg <= 1'b0;
            cap_chan_reg <= 4'h0;
            result_reg <= 12'h000;
        end else begin
            if (conv_req_next.start) begin
                busy_reg <= 1'b1;
                cap_chan_reg <= conv_req_next.channel;
            end else if (conv_end) begin
                busy_reg <= 1'b0;
            end
            if (cap_set) begin
                capture_run_reg <= 1'b1;
            end else if (stop_seen) begin
                capture_run_reg <= 1'b0;
            end
            if (sw_start) begin
                single_run_reg <= single_set;
            end
            if (conv_end) begin
                result_reg <= conv_result;
            end
        end
    end

endmodule

// file: dv/adc_conversion_control_asserts.sv
// Checker: port-level properties of the ADC conversion control block
module adc_conversion_control_asserts (
    // Clock, reset and register port
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Converter, memory and strobe
    input wire logic conv_done,
    input wire logic mem_ack,
    input wire logic [3:0] mem_chan_id,
    input wire adc_ctrl_pkg::conv_req_t conv_req,
    input wire adc_ctrl_pkg::mem_req_t mem_req,
    input wire logic ale_core,
    input wire logic ale_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A start always has a write, a finished conversion or a fetched id behind it;
    // a continuous restart comes one cycle after the idle state is reached, so two back
    chk_start_has_cause: assert property (conv_req.start |->
        $past(wr | conv_done | mem_ack) || $past(conv_done, 2))
        else $error("start without cause");
    // One conversion at a time: no second start before the first finishes
    chk_one_at_once: assert property (conv_req.start |=> !conv_req.start until conv_done)
        else $error("start while busy");
    chk_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    chk_unmapped_zero: assert property (rd && !(addr inside {8'h00, 8'h04, 8'h08, 8'h0c})
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_ale_follows: assert property (ale_out |-> $past(ale_core))
        else $error("strobe without core strobe");
    chk_capture_chan: assert property (mem_ack && mem_chan_id != 4'hf
        |=> conv_req.start && conv_req.channel == $past(mem_chan_id))
        else $error("capture channel not from memory");
    chk_capture_stop: assert property (mem_ack && mem_chan_id == 4'hf
        |=> (!conv_req.start && !mem_req.rd) [*2])
        else $error("capture ran past stop code");
    chk_fetch_pulse: assert property (mem_req.rd |=> !mem_req.rd)
        else $error("fetch longer than one cycle");
    // Main scenarios reached
    cover property (conv_req.start);
    cover property (mem_req.wr);
    cover property (mem_ack && mem_chan_id == 4'hf);
endmodule

bind adc_conversion_control adc_conversion_control_asserts i_chk (.clk, .rst, .addr, .wr, .rd,
    .rdata, .conv_done, .mem_ack, .mem_chan_id, .conv_req, .mem_req, .ale_core, .ale_out);

// file: dv/adc_conversion_control_test.sv
// Testbench: register, converter and capture-memory stimulus with expected values worked out in the sequence
module adc_conversion_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, wr = 0, rd = 0, vector_ack = 0, conv_done = 0, mem_ack = 0;
    logic ale_core = 1, irq, ale_out;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [11:0] conv_result = 12'h000;
    logic [3:0] mem_chan_id = 4'h0;
    adc_ctrl_pkg::conv_req_t conv_req;
    adc_ctrl_pkg::mem_req_t mem_req;
    int num_errors = 0, n_checks = 0, seed = 97, ch, res, ctrl_m;
    adc_conversion_control i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .vector_ack(vector_ack), .irq(irq), .conv_req(conv_req),
        .conv_done(conv_done), .conv_result(conv_result), .mem_req(mem_req), .mem_ack(mem_ack),
        .mem_chan_id(mem_chan_id), .ale_core(ale_core), .ale_out(ale_out));
    // 50 ns clock
    always #25 clk = ~clk;
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Bus cycles: strobes last one cycle, read data is taken in the following cycle only
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp(12'(rdata), 12'(e));
    endtask
    // Bounded wait for start (0), fetch (1) or store (2); a hang ends the run
    task automatic wait_on(input int which);
        for (int i = 0; i < 40; i++) begin
            #1;
            if ((which == 0 ? conv_req.start : which == 1 ? mem_req.rd : mem_req.wr) === 1'b1)
                return;
            @(posedge clk);
        end
        num_errors++;
        $display("wrong value at %0t: handshake timeout", $time);
        tally_and_finish();
    endtask
    // Converter and memory answers; released lines show the inverse, not the old value
    task automatic done_pulse(input logic [11:0] r);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_result <= r;
        @(posedge clk);
        conv_done <= 1'b0;
        conv_result <= ~r;
    endtask
    task automatic ack_id(input logic [3:0] id);
        @(posedge clk);
        mem_ack <= 1'b1;
        mem_chan_id <= id;
        @(posedge clk);
        mem_ack <= 1'b0;
        mem_chan_id <= ~id;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rreg(8'h00, 8'h00);
        rreg(8'h0c, 8'h00);
        rreg(8'h10, 8'h00);
        for (int k = 0; k < 4; k++) begin
            ch = $random(seed) & 7;
            ctrl_m = 8'h10 | ch;
            wreg(8'h0c, 8'(k > 0));
            wreg(8'h00, 8'(ctrl_m));
            wait_on(0);
            cmp(12'(conv_req.channel), 12'(ch));
            rreg(8'h04, 8'h80);
            done_pulse(12'(k));
            ctrl_m = (ctrl_m & 8'h0f) | 8'h80;
            rreg(8'h00, 8'(ctrl_m));
            rreg(8'h04, 8'h00);
            cmp(12'(irq), 12'(k > 0));
            if (k % 2 == 0) begin
                @(posedge clk) vector_ack <= 1'b1;
                @(posedge clk) vector_ack <= 1'b0;
            end else
                wreg(8'h00, 8'(ch));
            rreg(8'h00, 8'(ch));
            wreg(8'h08, 8'h01);
            rreg(8'h08, 8'h00);
            cmp(12'(irq), 12'h0);
        end
        // Continuous mode picks up a channel change at the next start
        wreg(8'h00, 8'h33);
        wait_on(0);
        done_pulse(12'h001);
        wait_on(0);
        cmp(12'(conv_req.channel), 12'h3);
        wreg(8'h00, 8'h25);
        done_pulse(12'h002);
        wait_on(0);
        cmp(12'(conv_req.channel), 12'h5);
        wreg(8'h00, 8'h00);
        done_pulse(12'h003);
        rreg(8'h04, 8'h00);
        // Block capture: one channel from memory, then the stop code
        wreg(8'h08, 8'h03);
        ch = ($random(seed) & 7) | 1;
        res = $random(seed) & 12'hfff;
        wreg(8'h00, 8'h40);
        // Strobe is held off in the cycle right after the enable write
        #1 cmp(12'(ale_out), 12'h0);
        wait_on(1);
        ack_id(4'(ch));
        wait_on(0);
        cmp(12'(conv_req.channel), 12'(ch));
        done_pulse(12'(res));
        wait_on(2);
        cmp(mem_req.data, 12'(res));
        wait_on(1);
        ack_id(4'hf);
        repeat (4) @(posedge clk);
        cmp(12'(ale_out), 12'h1);
        rreg(8'h00, 8'h80);
        rreg(8'h08, 8'h03);
        cmp(12'(irq), 12'h1);
        tally_and_finish();
    end
endmodule
